/* core/seq_mode_pkg.sv */
package seq_mode_pkg;

    localparam int NPAR  = 7;
    localparam int VW    = 16;
    localparam int NODES = 32;
    localparam int NIDX  = 5;
    localparam int CW    = 32;
    localparam int AW    = 8;

    // parameter slots, one source selection each
    localparam int P_AC_VOLT   = 0;
    localparam int P_DC_OFFS   = 1;
    localparam int P_WAVE      = 2;
    localparam int P_FREQ      = 3;
    localparam int P_AC_SLEW   = 4;
    localparam int P_DC_SLEW   = 5;
    localparam int P_FREQ_SLEW = 6;

    // a list start phase or an end phase of all ones stands for -1, meaning no phase given
    localparam logic [VW-1:0] PHASE_NONE = 16'hFFFF;

    localparam logic [AW-1:0] A_SRC_SEL   = 8'h00;
    localparam logic [AW-1:0] A_TRIG_EN   = 8'h04;
    localparam logic [AW-1:0] A_PULSE_DUR = 8'h08;
    localparam logic [AW-1:0] A_STEP_PH   = 8'h0C;
    localparam logic [AW-1:0] A_PULSE_PH  = 8'h10;
    localparam logic [AW-1:0] A_STATUS    = 8'h14;
    localparam logic [AW-1:0] A_BASIC     = 8'h40;
    localparam logic [AW-1:0] A_STEPV     = 8'h60;
    localparam logic [AW-1:0] A_PULSEV    = 8'h80;
    localparam logic [AW-1:0] A_SETPT     = 8'hA0;

    localparam int F_SPH   = 16;
    localparam int F_EPH   = 20;
    localparam int F_TMODE = 24;
    localparam int F_HI    = 16;

    typedef enum logic [1:0] {
        SRC_BASIC, SRC_STEP, SRC_PULSE, SRC_LIST
    } src_t;

    typedef enum logic [2:0] {
        SPH_OFF, SPH_STEP, SPH_PULSE, SPH_LIST, SPH_ANY_PROGRAM
    } sph_t;

    typedef enum logic [1:0] {
        EPH_OFF, EPH_PULSE, EPH_LIST, EPH_ANY_PROGRAM
    } eph_t;

    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [31:0]   pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic                     node_start;
        logic [NIDX-1:0]          node_idx;
        logic [NPAR-1:0][VW-1:0]  vals;
        logic [VW-1:0]            start_phase;
        logic [VW-1:0]            end_phase;
    } list_node_t;

    typedef struct packed {
        logic          start_load;
        logic [VW-1:0] start_phase;
        logic          end_en;
        logic [VW-1:0] end_phase;
    } phase_out_t;

    typedef struct packed {
        src_t [NPAR-1:0]          src;
        sph_t                     sph;
        eph_t                     eph;
        logic                     tmode;
        logic [NODES-1:0]         trig_en;
        logic [CW-1:0]            pulse_dur;
        logic [CW-1:0]            pulse_cnt;
        logic                     pulse_on;
        logic [VW-1:0]            step_sph;
        logic [VW-1:0]            pulse_sph;
        logic [VW-1:0]            pulse_eph;
        logic [NPAR-1:0][VW-1:0]  basic;
        logic [NPAR-1:0][VW-1:0]  stepv;
        logic [NPAR-1:0][VW-1:0]  pulsev;
        logic [NPAR-1:0][VW-1:0]  setpt;
        phase_out_t               ph;
        logic                     trig_out;
        apb_rsp_t                 rsp;
    } seq_state_t;

    // all selections at zero mean basic value source, phases off
    localparam seq_state_t STATE_RST = '0;

endpackage : seq_mode_pkg

/* core/sequencer_mode_select.sv */
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module sequencer_mode_select (
    input  logic                                pclk,
    input  logic                                presetn,
    input  seq_mode_pkg::apb_req_t              apb_in,
    output seq_mode_pkg::apb_rsp_t              apb_out,
    input  logic                                step_trig,
    input  logic                                pulse_trig,
    input  seq_mode_pkg::list_node_t            list_in,
    output logic [seq_mode_pkg::NPAR-1:0]
                 [seq_mode_pkg::VW-1:0]         setpoint,
    output seq_mode_pkg::phase_out_t            phase_out,
    output logic                                trigger_output,
    output logic                                pulse_busy
);
    import seq_mode_pkg::*;

    seq_state_t s_r;
    seq_state_t s_nxt;

    // bank of one word per parameter, seven words used out of eight
    function automatic logic bank_hit(input logic [AW-1:0] a,
                                      input logic [AW-1:0] base);
        bank_hit = (a[AW-1:5] == base[AW-1:5]) && (a[4:2] < 3'(NPAR))
                   && (a[1:0] == 2'b00);
    endfunction : bank_hit

    function automatic logic [31:0] widen(input logic [VW-1:0] v);
        widen = {{(32-VW){1'b0}}, v};
    endfunction : widen

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic          acc;
        logic          hit;
        logic [31:0]   rd;
        logic [2:0]    bi;
        logic          lst_sph;
        s_nxt   = s_r;
        acc     = apb_in.psel & apb_in.penable;
        hit     = 1'b1;
        rd      = '0;
        bi      = apb_in.paddr[4:2];
        lst_sph = list_in.node_start && (list_in.start_phase != PHASE_NONE);

        // register read decode
        case (apb_in.paddr)
            A_SRC_SEL: begin
                rd[2*NPAR-1:0]         = s_r.src;
                rd[F_SPH+2:F_SPH]      = s_r.sph;
                rd[F_EPH+1:F_EPH]      = s_r.eph;
                rd[F_TMODE]            = s_r.tmode;
            end
            A_TRIG_EN:   rd = s_r.trig_en;
            A_PULSE_DUR: rd = s_r.pulse_dur;
            A_STEP_PH:   rd = widen(s_r.step_sph);
            A_PULSE_PH:  rd = {s_r.pulse_eph, s_r.pulse_sph};
            A_STATUS:    rd = {31'h0000_0000, s_r.pulse_on};
            default: begin
                if (bank_hit(apb_in.paddr, A_BASIC)) begin
                    rd = widen(s_r.basic[bi]);
                end else if (bank_hit(apb_in.paddr, A_STEPV)) begin
                    rd = widen(s_r.stepv[bi]);
                end else if (bank_hit(apb_in.paddr, A_PULSEV)) begin
                    rd = widen(s_r.pulsev[bi]);
                end else if (bank_hit(apb_in.paddr, A_SETPT)) begin
                    rd = widen(s_r.setpt[bi]);
                end else begin
                    hit = 1'b0;
                end
            end
        endcase

        // one wait state: answer data is latched while pready is low
        s_nxt.rsp.pready = acc & ~s_r.rsp.pready;
        if (acc && !s_r.rsp.pready) begin
            s_nxt.rsp.prdata  = rd;
            s_nxt.rsp.pslverr = ~hit;
        end

        // writes take effect at the edge that samples pready high
        if (acc && s_r.rsp.pready && apb_in.pwrite && hit) begin
            case (apb_in.paddr)
                A_SRC_SEL: begin
                    for (int i = 0; i < NPAR; i++) begin
                        s_nxt.src[i] = src_t'(apb_in.pwdata[$bits(src_t)*i
                                       +: $bits(src_t)]);
                    end
                    s_nxt.sph   = sph_t'(apb_in.pwdata[F_SPH+2:F_SPH]);
                    s_nxt.eph   = eph_t'(apb_in.pwdata[F_EPH+1:F_EPH]);
                    s_nxt.tmode = apb_in.pwdata[F_TMODE];
                end
                A_TRIG_EN:   s_nxt.trig_en   = apb_in.pwdata;
                A_PULSE_DUR: s_nxt.pulse_dur = apb_in.pwdata;
                A_STEP_PH:   s_nxt.step_sph  = apb_in.pwdata[VW-1:0];
                A_PULSE_PH: begin
                    s_nxt.pulse_sph = apb_in.pwdata[VW-1:0];
                    s_nxt.pulse_eph = apb_in.pwdata[F_HI+VW-1:F_HI];
                end
                default: begin
                    if (bank_hit(apb_in.paddr, A_BASIC)) begin
                        s_nxt.basic[bi] = apb_in.pwdata[VW-1:0];
                    end else if (bank_hit(apb_in.paddr, A_STEPV)) begin
                        s_nxt.stepv[bi] = apb_in.pwdata[VW-1:0];
                    end else if (bank_hit(apb_in.paddr, A_PULSEV)) begin
                        s_nxt.pulsev[bi] = apb_in.pwdata[VW-1:0];
                    end
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // pulse window: a retrigger restarts the full duration
        if (pulse_trig) begin
            s_nxt.pulse_cnt = s_r.pulse_dur;
        end else if (s_r.pulse_cnt != '0) begin
            s_nxt.pulse_cnt = s_r.pulse_cnt - CW'(1);
        end
        s_nxt.pulse_on = (s_nxt.pulse_cnt != '0);

        for (int i = 0; i < NPAR; i++) begin
            case (s_r.src[i])
                SRC_BASIC: s_nxt.setpt[i] = s_r.basic[i];
                SRC_STEP: begin
                    if (step_trig) begin
                        s_nxt.setpt[i] = s_r.stepv[i];
                    end
                end
                SRC_PULSE: begin
                    if (pulse_trig) begin
                        s_nxt.setpt[i] = s_r.pulsev[i];
                    end else if (s_r.pulse_cnt <= CW'(1)) begin
                        s_nxt.setpt[i] = s_r.basic[i];
                    end
                end
                SRC_LIST: begin
                    if (list_in.node_start) begin
                        s_nxt.setpt[i] = list_in.vals[i];
                    end
                end
                default: s_nxt.setpt[i] = s_r.basic[i];
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // start phase: no load leaves the phase running on (continuity)
        s_nxt.ph.start_load = 1'b0;
        if ((s_r.sph == SPH_STEP || s_r.sph == SPH_ANY_PROGRAM)
            && step_trig) begin
            s_nxt.ph.start_load  = 1'b1;
            s_nxt.ph.start_phase = s_r.step_sph;
        end else if ((s_r.sph == SPH_PULSE || s_r.sph == SPH_ANY_PROGRAM)
                     && pulse_trig) begin
            s_nxt.ph.start_load  = 1'b1;
            s_nxt.ph.start_phase = s_r.pulse_sph;
        end else if ((s_r.sph == SPH_LIST || s_r.sph == SPH_ANY_PROGRAM)
                     && lst_sph) begin
            // a -1 entry never gets here, so the node continues
            s_nxt.ph.start_load  = 1'b1;
            s_nxt.ph.start_phase = list_in.start_phase;
        end

        // end phase stands as a level until a program replaces it or end phase sourcing is set off
        if (s_r.eph == EPH_OFF) begin
            s_nxt.ph.end_en = 1'b0;
        end else if ((s_r.eph == EPH_PULSE || s_r.eph == EPH_ANY_PROGRAM)
                     && pulse_trig) begin
            s_nxt.ph.end_en    = (s_r.pulse_eph != PHASE_NONE);
            s_nxt.ph.end_phase = s_r.pulse_eph;
        end else if ((s_r.eph == EPH_LIST || s_r.eph == EPH_ANY_PROGRAM)
                     && list_in.node_start) begin
            s_nxt.ph.end_en    = (list_in.end_phase != PHASE_NONE);
            s_nxt.ph.end_phase = list_in.end_phase;
        end

        s_nxt.trig_out = list_in.node_start && s_r.tmode
                         && s_r.trig_en[list_in.node_idx];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign apb_out        = s_r.rsp;
    assign setpoint       = s_r.setpt;
    assign phase_out      = s_r.ph;
    assign trigger_output = s_r.trig_out;
    assign pulse_busy     = s_r.pulse_on;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    trig_gen_a: assert property (
        list_in.node_start && s_r.tmode && s_r.trig_en[list_in.node_idx]
        |=> trigger_output)
        else $error("enabled node start gave no trigger pulse");

    trig_gate_a: assert property (
        trigger_output |-> $past(s_r.tmode) && $past(list_in.node_start))
        else $error("trigger pulse outside trigger mode or node start");

    basic_track_a: assert property (
        s_r.src[P_AC_VOLT] == SRC_BASIC
        |=> setpoint[P_AC_VOLT] == $past(s_r.basic[P_AC_VOLT]))
        else $error("basic source did not follow basic value");

    step_hold_a: assert property (
        s_r.src[P_FREQ] == SRC_STEP && !step_trig
        |=> $stable(setpoint[P_FREQ]))
        else $error("step source value changed without trigger");

    pulse_apply_a: assert property (
        s_r.src[P_WAVE] == SRC_PULSE && pulse_trig
        |=> setpoint[P_WAVE] == $past(s_r.pulsev[P_WAVE]))
        else $error("pulse value not applied on trigger");

    pulse_revert_a: assert property (
        s_r.src[P_WAVE] == SRC_PULSE && !pulse_trig
        && s_r.pulse_cnt == CW'(1) ##1 s_r.src[P_WAVE] == SRC_PULSE
        |-> setpoint[P_WAVE] == s_r.basic[P_WAVE] || $changed(s_r.basic))
        else $error("pulse did not revert to basic value");

    list_load_a: assert property (
        s_r.src[P_DC_OFFS] == SRC_LIST && list_in.node_start
        |=> setpoint[P_DC_OFFS] == $past(list_in.vals[P_DC_OFFS]))
        else $error("list source did not load node value");

    start_off_a: assert property (
        s_r.sph == SPH_OFF |=> !phase_out.start_load)
        else $error("start phase loaded while sourcing is off");

    start_prio_a: assert property (
        s_r.sph == SPH_ANY_PROGRAM && step_trig
        |=> phase_out.start_load
            && phase_out.start_phase == $past(s_r.step_sph))
        else $error("step did not win start phase priority");

    start_none_a: assert property (
        s_r.sph == SPH_LIST && list_in.node_start
        && list_in.start_phase == PHASE_NONE |=> !phase_out.start_load)
        else $error("minus one start phase broke continuity");

    end_off_a: assert property (
        s_r.eph == EPH_OFF |=> !phase_out.end_en)
        else $error("end phase active while sourcing is off");

    end_prio_a: assert property (
        s_r.eph == EPH_ANY_PROGRAM && pulse_trig && list_in.node_start
        |=> phase_out.end_phase == $past(s_r.pulse_eph))
        else $error("pulse did not win end phase priority");

    end_none_a: assert property (
        s_r.eph == EPH_LIST && list_in.node_start
        && list_in.end_phase == PHASE_NONE |=> !phase_out.end_en)
        else $error("minus one end phase left condition enabled");

    trig_off_a: assert property (
        list_in.node_start && !s_r.trig_en[list_in.node_idx]
        |=> !trigger_output)
        else $error("disabled node start gave a trigger pulse");

    trig_mode_a: assert property (
        list_in.node_start && !s_r.tmode
        |=> !trigger_output)
        else $error("trigger pulse while output mode is not trigger");

    basic_slew_a: assert property (
        s_r.src[P_FREQ_SLEW] == SRC_BASIC
        |=> setpoint[P_FREQ_SLEW] == $past(s_r.basic[P_FREQ_SLEW]))
        else $error("basic source slew did not follow basic value");

    src_indep_a: assert property (
        s_r.src[P_AC_SLEW] == SRC_BASIC && step_trig
        |=> setpoint[P_AC_SLEW] == $past(s_r.basic[P_AC_SLEW]))
        else $error("step trigger disturbed a basic sourced parameter");

    step_load_a: assert property (
        s_r.src[P_FREQ] == SRC_STEP && step_trig
        |=> setpoint[P_FREQ] == $past(s_r.stepv[P_FREQ]))
        else $error("step value not loaded on trigger");

    pulse_busy_a: assert property (
        pulse_trig && s_r.pulse_dur != '0
        |=> pulse_busy)
        else $error("pulse window not opened on trigger");

    list_hold_a: assert property (
        s_r.src[P_DC_OFFS] == SRC_LIST && !list_in.node_start
        |=> $stable(setpoint[P_DC_OFFS]))
        else $error("list source value changed without node start");

    start_step_a: assert property (
        s_r.sph == SPH_STEP && step_trig
        |=> phase_out.start_load && phase_out.start_phase == $past(s_r.step_sph))
        else $error("step start phase not loaded on trigger");

    start_pulse_a: assert property (
        s_r.sph == SPH_PULSE && pulse_trig
        |=> phase_out.start_load && phase_out.start_phase == $past(s_r.pulse_sph))
        else $error("pulse start phase not loaded on trigger");

    start_list_a: assert property (
        s_r.sph == SPH_LIST && list_in.node_start
        && list_in.start_phase != PHASE_NONE |=> phase_out.start_load)
        else $error("list start phase not loaded at node start");

    start_second_a: assert property (
        s_r.sph == SPH_ANY_PROGRAM && !step_trig && pulse_trig
        |=> phase_out.start_phase == $past(s_r.pulse_sph))
        else $error("pulse did not win start phase over list");

    end_pulse_a: assert property (
        s_r.eph == EPH_PULSE && pulse_trig && s_r.pulse_eph != PHASE_NONE
        |=> phase_out.end_en && phase_out.end_phase == $past(s_r.pulse_eph))
        else $error("pulse end phase not applied on trigger");

    end_list_a: assert property (
        s_r.eph == EPH_LIST && list_in.node_start
        && list_in.end_phase != PHASE_NONE |=> phase_out.end_en)
        else $error("list end phase not applied at node start");

    end_any_list_a: assert property (
        s_r.eph == EPH_ANY_PROGRAM && !pulse_trig && list_in.node_start
        |=> phase_out.end_phase == $past(list_in.end_phase))
        else $error("list end phase not taken without pulse trigger");

endmodule : sequencer_mode_select

/* verif/apb_host.sv */
`timescale 1ns/1ps

module apb_host (
    input  wire logic                pclk,
    output seq_mode_pkg::apb_req_t   req,
    input  seq_mode_pkg::apb_rsp_t   rsp
);
    import seq_mode_pkg::*;

    initial req = '0;

    // the request stays put until pready is seen high at an edge;
    // no wait length is assumed, only the bench timeout ends a hang
    task automatic xfer(input  logic          wr,
                        input  logic [AW-1:0] a,
                        input  logic [31:0]   d,
                        output logic [31:0]   q,
                        output logic          err);
        @(posedge pclk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        q   = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : xfer

endmodule : apb_host

/* verif/test_sequencer_mode_select.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; \
    if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, g); end end

module test_sequencer_mode_select;
    import seq_mode_pkg::*;

    logic                    pclk = 1'b0;
    logic                    presetn = 1'b0;
    apb_req_t                req;
    apb_rsp_t                rsp;
    logic                    step_trig = 1'b0;
    logic                    pulse_trig = 1'b0;
    list_node_t              list_in = '0;
    logic [NPAR-1:0][VW-1:0] setpoint;
    phase_out_t              phase_out;
    logic                    trigger_output;
    logic                    pulse_busy;
    logic [31:0]             q;
    logic                    e;
    int                      err_total = 0;
    int                      total_checks = 0;
    int                      cyc = 0;

    always #2.5 pclk = ~pclk;

    apb_host host (.pclk(pclk), .req(req), .rsp(rsp));

    sequencer_mode_select dut (
        .pclk(pclk), .presetn(presetn), .apb_in(req), .apb_out(rsp),
        .step_trig(step_trig), .pulse_trig(pulse_trig),
        .list_in(list_in), .setpoint(setpoint), .phase_out(phase_out),
        .trigger_output(trigger_output), .pulse_busy(pulse_busy));

    ////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [AW-1:0] a);
        host.xfer(1'b0, a, 32'h0000_0000, q, e);
    endtask : rd

    // basic values follow their register one cycle late
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    task automatic fire(input logic s, input logic p, input logic n);
        @(posedge pclk);
        step_trig          <= s;
        pulse_trig         <= p;
        list_in.node_start <= n;
        @(posedge pclk);
        step_trig          <= 1'b0;
        pulse_trig         <= 1'b0;
        list_in.node_start <= 1'b0;
        #1;
    endtask : fire

    task automatic node(input logic [NIDX-1:0] i, input logic [VW-1:0] v,
                        input logic [VW-1:0] sp, input logic [VW-1:0] ep);
        @(posedge pclk);
        list_in.node_idx    <= i;
        list_in.vals        <= {NPAR{v}};
        list_in.start_phase <= sp;
        list_in.end_phase   <= ep;
        fire(1'b0, 1'b0, 1'b1);
    endtask : node

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(A_SRC_SEL);
        `CHK("src_sel", 32'h0000_0000, q)
        rd(8'h30);
        `CHK("unmapped_err", 1'b1, e)
        `CHK("unmapped_data", 32'h0000_0000, q)
        for (int i = 0; i < NPAR; i++)
            wr(AW'(A_BASIC + 4 * i), 32'h0000_1000 + i);
        settle;
        for (int i = 0; i < NPAR; i++)
            `CHK("basic_sp", VW'(16'h1000 + i), setpoint[i])
        rd(A_SETPT + 8'h0C);
        `CHK("setpt_rb", 32'h0000_1003, q)
        $display("t_reset done");
    endtask : t_reset

    task automatic t_step;
        wr(A_STEPV + 8'h0C, 32'h0000_0333);
        wr(A_STEP_PH, 32'h0000_0055);
        wr(A_SRC_SEL, 32'h0001_0040);
        fire(1'b1, 1'b0, 1'b0);
        `CHK("step_sp", 16'h0333, setpoint[3])
        `CHK("step_sp_other", 16'h1000, setpoint[0])
        `CHK("step_load", 1'b1, phase_out.start_load)
        `CHK("step_ph", 16'h0055, phase_out.start_phase)
        wr(A_STEPV + 8'h0C, 32'h0000_0444);
        settle;
        `CHK("step_hold", 16'h0333, setpoint[3])
        $display("t_step done");
    endtask : t_step

    task automatic t_pulse;
        wr(A_PULSE_DUR, 32'h0000_0003);
        wr(A_PULSEV + 8'h04, 32'h0000_0777);
        wr(A_PULSE_PH, 32'h0088_0011);
        wr(A_SRC_SEL, 32'h0010_0028);
        fire(1'b0, 1'b1, 1'b0);
        `CHK("pulse_sp", 16'h0777, setpoint[1])
        `CHK("pulse_busy", 1'b1, pulse_busy)
        `CHK("pulse_eph_en", 1'b1, phase_out.end_en)
        `CHK("pulse_eph", 16'h0088, phase_out.end_phase)
        `CHK("sph_off_load", 1'b0, phase_out.start_load)
        repeat (2) @(posedge pclk);
        #1;
        `CHK("pulse_sp_mid", 16'h0777, setpoint[1])
        @(posedge pclk);
        #1;
        `CHK("pulse_sp_end", 16'h1001, setpoint[1])
        `CHK("pulse_idle", 1'b0, pulse_busy)
        wr(A_SRC_SEL, 32'h0012_0028);
        fire(1'b0, 1'b1, 1'b0);
        `CHK("pulse_sph_load", 1'b1, phase_out.start_load)
        `CHK("pulse_sph", 16'h0011, phase_out.start_phase)
        $display("t_pulse done");
    endtask : t_pulse

    task automatic t_list;
        wr(A_TRIG_EN, 32'h0000_0004);
        wr(A_SRC_SEL, 32'h0123_003C);
        node(5'd2, 16'h0AAA, 16'h0022, PHASE_NONE);
        `CHK("list_sp", 16'h0AAA, setpoint[2])
        `CHK("list_sp_dc", 16'h0AAA, setpoint[1])
        `CHK("trig_on", 1'b1, trigger_output)
        `CHK("list_load", 1'b1, phase_out.start_load)
        `CHK("list_sph", 16'h0022, phase_out.start_phase)
        `CHK("list_eph_none", 1'b0, phase_out.end_en)
        node(5'd3, 16'h0BBB, PHASE_NONE, 16'h0033);
        `CHK("trig_off", 1'b0, trigger_output)
        `CHK("sph_none", 1'b0, phase_out.start_load)
        `CHK("list_eph_en", 1'b1, phase_out.end_en)
        `CHK("list_eph", 16'h0033, phase_out.end_phase)
        // trigger mode cleared and end phase sourcing off
        wr(A_SRC_SEL, 32'h0003_003C);
        settle;
        `CHK("eph_off", 1'b0, phase_out.end_en)
        node(5'd2, 16'h0AAA, 16'h0022, 16'h0033);
        `CHK("trig_mode_off", 1'b0, trigger_output)
        $display("t_list done");
    endtask : t_list

    task automatic t_any;
        logic [VW-1:0] sx [3];
        logic [VW-1:0] ex [3];
        sx = '{16'h0055, 16'h0011, 16'h0022};
        ex = '{16'h0088, 16'h0088, 16'h0033};
        wr(A_SRC_SEL, 32'h0034_0000);
        for (int k = 0; k < 3; k++) begin
            fire(k == 0, k < 2, 1'b1);
            `CHK("any_sph", sx[k], phase_out.start_phase)
            `CHK("any_eph", ex[k], phase_out.end_phase)
        end
        $display("t_any done");
    endtask : t_any

    ////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    // the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            stop_test;
        end
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_step;
        t_pulse;
        t_list;
        t_any;
        stop_test;
    end

endmodule : test_sequencer_mode_select
